/* offset_regs_defines.svh */
// constants of the offset and clock control register bank
// assumes a 32-bit bus with one register per aligned word
`ifndef OFFSET_REGS_DEFINES_SVH
`define OFFSET_REGS_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_OFFSET_LOW 8'h66
`define IDX_OFFSET_HIGH 8'h67
`define IDX_FLAG_CTRL 8'h68
`define IDX_PLL_CAL 8'h6b
`define IDX_PLL_CLK 8'h6d
`define IDX_CAL_STATUS 8'hd1

// reset values
`define RST_OFFSET_BYTE 8'h00
`define RST_FLAG_CTRL 8'h24
`define RST_PLL_CAL 8'h08
`define RST_PLL_CLK 8'h00

// field positions
`define BIT_FLAG_INVERT 3
`define BIT_FLAG_ENABLE 2
`define BIT_RECAL_TOGGLE 2
`define BIT_PLL_CLK_EN 5
`define DLY_MSB 3
`define DLY_LSB 1
`define PLL_CLK_WMASK 8'h3f
`define BIT_CAL_BUSY 0

// widths and limits
`define SAMPLE_W 12
`define OFFSET_W 16
`define SUM_W 18
`define FRAC_W 2
`define SAT_POS 12'h7ff
`define SAT_NEG 12'h800
`define DLY_SEL_W 4
`define DLY_DEPTH 16
`define DLY_BIG_BASE 4'h8

// bus
`define HTRANS_NONSEQ_BIT 1
`define RESP_OKAY 1'b0
`define BYTE_ZERO_PAD 24'h00_0000

`endif

/* offset_regs_pkg.sv */
// types shared by the offset and clock control register bank
// assumes the defines header is on the include path
`include "offset_regs_defines.svh"
package offset_regs_pkg;
	typedef struct packed {
		logic overrange_flag;
		logic word_clock_flag;
	} flag_pair_t;

	typedef logic [`SAMPLE_W-1:0] sample_t;
endpackage

/* offset_saturator.sv */
// adds a quarter-lsb offset to one sample and clamps to the code range
// assumes samples are two's complement and synchronous to hclk
`timescale 1ns/1ns
`include "offset_regs_defines.svh"
module offset_saturator (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// data
	input wire offset_regs_pkg::sample_t sample_in,
	input wire logic [`OFFSET_W-1:0] offset,
	output offset_regs_pkg::sample_t sample_out
);
	import offset_regs_pkg::*;

	sample_t out_reg;
	sample_t out_next;
	logic signed [`SUM_W-1:0] sum;
	logic signed [`SUM_W-1:0] whole;

	always_comb begin
		// sample scaled to quarter steps, offset sign extended
		sum = $signed({{(`SUM_W-`SAMPLE_W-`FRAC_W){sample_in[`SAMPLE_W-1]}},
			sample_in, {`FRAC_W{1'b0}}})
			+ $signed({{(`SUM_W-`OFFSET_W){offset[`OFFSET_W-1]}}, offset});
		whole = sum >>> `FRAC_W;
		// clamp instead of wrap
		if (whole[`SUM_W-1:`SAMPLE_W-1] != {(`SUM_W-`SAMPLE_W+1){whole[`SUM_W-1]}})
			out_next = whole[`SUM_W-1] ? `SAT_NEG : `SAT_POS;
		else
			out_next = whole[`SAMPLE_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			out_reg <= '0;
		else if (ce)
			out_reg <= out_next;
	end

	assign sample_out = out_reg;
endmodule // offset_saturator

/* cycle_delay_line.sv */
// delays a clock-rate level by a selectable number of cycles
// assumes the input is sampled synchronously to hclk
`timescale 1ns/1ns
`include "offset_regs_defines.svh"
module cycle_delay_line (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// data
	input wire logic din,
	input wire logic [`DLY_SEL_W-1:0] sel,
	output logic dout
);
	logic [`DLY_DEPTH-1:0] tap_reg;
	logic [`DLY_DEPTH-1:0] tap_next;
	logic out_reg;
	logic out_next;

	assign tap_next[0] = din;
	genvar i;
	generate
		for (i = 1; i < `DLY_DEPTH; i++) begin : g_tap
			assign tap_next[i] = tap_reg[i-1];
		end
	endgenerate

	always_comb begin
		// tap 0 is the undelayed input
		out_next = tap_next[sel];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tap_reg <= '0;
			out_reg <= 1'b0;
		end else if (ce) begin
			tap_reg <= tap_next;
			out_reg <= out_next;
		end
	end

	assign dout = out_reg;
endmodule // cycle_delay_line

/* offset_clock_regs.sv */
// ahb-lite register bank for output offset, flag pair and pll clock
// assumes one clock, single word transfers, synchronous pin inputs
//
// Functional notes
// - every adc sample gets the programmed offset added before output
// - offset is one signed 16-bit value from high and low bytes
// - one offset unit is a quarter output lsb; zero means no offset
// - low byte holds bits 7..0, next index bits 15..8, both reset zero
// - flag pair driven only when enabled, inverted when invert bit set
// - any change of the recalibration bit starts a pll calibration
// - calibration progress readable as a flag at a higher index
// - pll clock passed on only when its enable bit is set, reset off
// - delay applies only when decimation is not in use
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
`include "offset_regs_defines.svh"
module offset_clock_regs (
	// clock, reset, enable
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// sample path
	input wire offset_regs_pkg::sample_t adc_sample,
	input wire offset_regs_pkg::flag_pair_t adc_flags,
	output offset_regs_pkg::sample_t out_sample,
	output offset_regs_pkg::flag_pair_t out_flags,
	output logic flag_pair_oe_n,
	// pll
	input wire logic pll_clk_in,
	input wire logic pll_is_source,
	input wire logic decimation_active,
	input wire logic pll_cal_busy,
	output logic pll_cal_start,
	output logic pll_clk_out
);
	import offset_regs_pkg::*;

	// maps the 3-bit delay code to a cycle count
	function automatic logic [`DLY_SEL_W-1:0] dly_cycles(
		input logic [`DLY_MSB-`DLY_LSB:0] code);
		logic [`DLY_SEL_W-1:0] c;
		c = {1'b0, code};
		if (code == '0 || code == {{(`DLY_MSB-`DLY_LSB){1'b0}}, 1'b1})
			dly_cycles = c;
		else
			dly_cycles = c + `DLY_BIG_BASE;
	endfunction

	// decodes a word address into a register index, valid when mapped
	function automatic logic [8:0] addr_index(input logic [31:0] a);
		addr_index = {(a[31:10] == '0) && (a[1:0] == '0), a[9:2]};
	endfunction

	logic [7:0] off_lo_reg, off_lo_next;
	logic [7:0] off_hi_reg, off_hi_next;
	logic [7:0] flag_ctrl_reg, flag_ctrl_next;
	logic [7:0] pll_cal_reg, pll_cal_next;
	logic [7:0] pll_clk_reg, pll_clk_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_idx_reg, wr_idx_next;
	logic [31:0] rdata_reg, rdata_next;
	logic cal_start_reg, cal_start_next;
	logic [8:0] addr_dec;
	logic take;
	logic [7:0] rd_byte;

	// bus and register file
	always_comb begin
		off_lo_next = off_lo_reg;
		off_hi_next = off_hi_reg;
		flag_ctrl_next = flag_ctrl_reg;
		pll_cal_next = pll_cal_reg;
		pll_clk_next = pll_clk_reg;
		cal_start_next = 1'b0;
		// data phase of a write
		if (wr_pend_reg) begin
			case (wr_idx_reg)
				`IDX_OFFSET_LOW: off_lo_next = hwdata[7:0];
				`IDX_OFFSET_HIGH: off_hi_next = hwdata[7:0];
				`IDX_FLAG_CTRL: flag_ctrl_next = hwdata[7:0];
				`IDX_PLL_CAL: begin
					pll_cal_next = hwdata[7:0];
					cal_start_next = hwdata[`BIT_RECAL_TOGGLE]
						!= pll_cal_reg[`BIT_RECAL_TOGGLE];
				end
				`IDX_PLL_CLK: pll_clk_next = hwdata[7:0] & `PLL_CLK_WMASK;
				default: ;
			endcase
		end
		// address phase
		addr_dec = addr_index(haddr);
		take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
		wr_pend_next = take && hwrite && addr_dec[8];
		wr_idx_next = addr_dec[7:0];
		// read sees a write still in its data phase
		case (addr_dec[7:0])
			`IDX_OFFSET_LOW: rd_byte = off_lo_next;
			`IDX_OFFSET_HIGH: rd_byte = off_hi_next;
			`IDX_FLAG_CTRL: rd_byte = flag_ctrl_next;
			`IDX_PLL_CAL: rd_byte = pll_cal_next;
			`IDX_PLL_CLK: rd_byte = pll_clk_next;
			`IDX_CAL_STATUS: begin
				rd_byte = 8'h00;
				rd_byte[`BIT_CAL_BUSY] = pll_cal_busy;
			end
			default: rd_byte = 8'h00;
		endcase
		if (!addr_dec[8])
			rd_byte = 8'h00;
		rdata_next = rdata_reg;
		if (take && !hwrite)
			rdata_next = {`BYTE_ZERO_PAD, rd_byte};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			off_lo_reg <= `RST_OFFSET_BYTE;
			off_hi_reg <= `RST_OFFSET_BYTE;
			flag_ctrl_reg <= `RST_FLAG_CTRL;
			pll_cal_reg <= `RST_PLL_CAL;
			pll_clk_reg <= `RST_PLL_CLK;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
			rdata_reg <= '0;
			cal_start_reg <= 1'b0;
		end else if (ce) begin
			off_lo_reg <= off_lo_next;
			off_hi_reg <= off_hi_next;
			flag_ctrl_reg <= flag_ctrl_next;
			pll_cal_reg <= pll_cal_next;
			pll_clk_reg <= pll_clk_next;
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			rdata_reg <= rdata_next;
			cal_start_reg <= cal_start_next;
		end
	end

	// zero wait states, always okay
	logic ready_reg;
	logic resp_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_reg <= 1'b1;
			resp_reg <= `RESP_OKAY;
		end else if (ce) begin
			ready_reg <= 1'b1;
			resp_reg <= `RESP_OKAY;
		end
	end

	// sample path with offset
	offset_saturator u_sat (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.sample_in(adc_sample),
		.offset({off_hi_reg, off_lo_reg}),
		.sample_out(out_sample)
	);

	// flag pair, aligned with the offset stage
	flag_pair_t flags_reg, flags_next;
	logic oe_n_reg, oe_n_next;
	always_comb begin
		oe_n_next = !flag_ctrl_reg[`BIT_FLAG_ENABLE];
		flags_next = '0;
		if (flag_ctrl_reg[`BIT_FLAG_ENABLE])
			flags_next = adc_flags
				^ {2{flag_ctrl_reg[`BIT_FLAG_INVERT]}};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg <= '0;
			oe_n_reg <= 1'b0;
		end else if (ce) begin
			flags_reg <= flags_next;
			oe_n_reg <= oe_n_next;
		end
	end

	// pll clock delay and gate
	logic [`DLY_SEL_W-1:0] dly_sel;
	logic dly_out;
	logic pclk_reg, pclk_next;
	always_comb begin
		dly_sel = '0;
		if (pll_is_source && !decimation_active)
			dly_sel = dly_cycles(pll_clk_reg[`DLY_MSB:`DLY_LSB]);
		pclk_next = pll_clk_reg[`BIT_PLL_CLK_EN] && dly_out;
	end

	cycle_delay_line u_dly (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.din(pll_clk_in),
		.sel(dly_sel),
		.dout(dly_out)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pclk_reg <= 1'b0;
		else if (ce)
			pclk_reg <= pclk_next;
	end

	assign hrdata = rdata_reg;
	assign hreadyout = ready_reg;
	assign hresp = resp_reg;
	assign out_flags = flags_reg;
	assign flag_pair_oe_n = oe_n_reg;
	assign pll_cal_start = cal_start_reg;
	assign pll_clk_out = pclk_reg;
endmodule // offset_clock_regs

/* pll_cal_model.sv */
// pll calibration model: answers a start pulse with a busy level
// assumes start is a one-cycle pulse synchronous to hclk
`timescale 1ns/1ns
module pll_cal_model #(parameter int BUSY_CYCLES = 8) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// calibration
	input wire logic pll_cal_start,
	output logic pll_cal_busy
);
	logic [7:0] cnt_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cnt_reg <= 8'h00;
		else if (pll_cal_start)
			cnt_reg <= BUSY_CYCLES[7:0];
		else if (cnt_reg != 8'h00)
			cnt_reg <= cnt_reg - 8'h01;
	end
	assign pll_cal_busy = cnt_reg != 8'h00;
endmodule // pll_cal_model

/* offset_clock_regs_assertions.sv */
// checker of bus answer, flag pair and calibration pulse
// assumes it is bound to offset_clock_regs
`timescale 1ns/1ns
`include "offset_regs_defines.svh"
module offset_clock_regs_assertions (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// pins
	input wire offset_regs_pkg::flag_pair_t adc_flags,
	input wire offset_regs_pkg::flag_pair_t out_flags,
	input wire logic flag_pair_oe_n,
	input wire offset_regs_pkg::sample_t out_sample,
	input wire logic pll_cal_busy,
	input wire logic pll_cal_start
);
	import offset_regs_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_ph;
	assign rd_ph = ce && hsel && hready && htrans[1] && !hwrite;
	property p_ready; hreadyout && !hresp; endproperty
	a_ready: assert property (p_ready) else $error("bus answer wrong");
	property p_hi; hrdata[31:8] == 24'h00_0000; endproperty
	a_hi: assert property (p_hi) else $error("read data high bits set");
	// misaligned address or unused index 0x70 reads back zero
	property p_unmap;
		rd_ph && (haddr[1:0] != 2'b00 || haddr[9:2] == 8'h70)
			|=> hrdata == '0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
	property p_stat;
		rd_ph && haddr == {22'h00_0000, `IDX_CAL_STATUS, 2'b00}
			|=> hrdata[0] == $past(pll_cal_busy);
	endproperty
	a_stat: assert property (p_stat) else $error("status bit wrong");
	property p_pulse; pll_cal_start |=> !pll_cal_start; endproperty
	a_pulse: assert property (p_pulse) else $error("start not a pulse");
	property p_off; flag_pair_oe_n |-> out_flags == 2'b00; endproperty
	a_off: assert property (p_off) else $error("disabled pair driven");
	property p_pair;
		!flag_pair_oe_n && $past(ce) && $past(hresetn) |->
			out_flags == $past(adc_flags) || out_flags == ~$past(adc_flags);
	endproperty
	a_pair: assert property (p_pair) else $error("pair not passed");
	property p_frz; !ce |=> $stable(out_sample) && $stable(hrdata); endproperty
	a_frz: assert property (p_frz) else $error("state moved with ce low");
endmodule // offset_clock_regs_assertions
bind offset_clock_regs offset_clock_regs_assertions
	u_offset_clock_regs_assertions (.hclk, .hresetn, .ce, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .adc_flags,
	.out_flags, .flag_pair_oe_n, .out_sample, .pll_cal_busy, .pll_cal_start);

/* tb.sv */
// testbench of the offset and clock register bank
// assumes zero-wait ahb-lite slave and the calibration model
`timescale 1ns/1ns
`include "offset_regs_defines.svh"
module tb;
	import offset_regs_pkg::*;
	logic hclk = 0, hresetn = 0, ce = 1, hwrite = 0, pll_clk_in = 0;
	logic pll_is_source = 0, decimation_active = 0, hreadyout, hresp;
	logic flag_pair_oe_n, pll_cal_busy, pll_cal_start, pll_clk_out;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, hist = '0, rd;
	sample_t adc_sample = '0, out_sample;
	flag_pair_t adc_flags = '0, out_flags;
	int fails = 0, n_checks = 0, pulses = 0, cyc = 0;
	logic [15:0] offs [5] = '{16'h0000, 16'h0004, 16'hfff8, 16'h7fff, 16'h8000};
	sample_t smp [5] = '{12'h123, 12'h005, 12'h000, 12'h7f0, 12'h800};
	always #5 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		pll_clk_in <= (cyc % 11) < 4;
		hist <= {hist[30:0], pll_clk_in};
		if (pll_cal_start === 1'b1)
			pulses <= pulses + 1;
	end
	offset_clock_regs u_offset_clock_regs (.hclk, .hresetn, .ce,
		.hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .adc_sample,
		.adc_flags, .out_sample, .out_flags, .flag_pair_oe_n, .pll_clk_in,
		.pll_is_source, .decimation_active, .pll_cal_busy, .pll_cal_start,
		.pll_clk_out);
	pll_cal_model u_pll_cal_model (.hclk, .hresetn, .pll_cal_start,
		.pll_cal_busy);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic edge_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			end_of_test();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h00_0000, idx, 2'b00};
		edge_ready();
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		edge_ready();
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		chk(rd, {24'h00_0000, e});
	endtask
	function automatic sample_t exp_out(sample_t s, logic [15:0] o);
		logic signed [17:0] q;
		q = {{4{s[11]}}, s, 2'b00} + {{2{o[15]}}, o};
		q = q >>> 2;
		if (q > 18'sd2047)
			return 12'h7ff;
		if (q < -18'sd2048)
			return 12'h800;
		return q[11:0];
	endfunction
	// tap is the history index matching the expected delay
	task automatic dly(input logic [7:0] ctrl, input int tap);
		xfer(1'b1, `IDX_PLL_CLK, ctrl);
		repeat (24) @(posedge hclk);
		repeat (8) begin
			@(negedge hclk);
			chk(pll_clk_out, ctrl[5] & hist[tap]);
		end
		@(posedge hclk);
	endtask
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rdchk(`IDX_OFFSET_LOW, 8'h00);
		rdchk(`IDX_OFFSET_HIGH, 8'h00);
		rdchk(`IDX_FLAG_CTRL, 8'h24);
		rdchk(`IDX_PLL_CAL, 8'h08);
		rdchk(`IDX_PLL_CLK, 8'h00);
		xfer(1'b1, `IDX_PLL_CLK, 8'hff);
		rdchk(`IDX_PLL_CLK, 8'h3f);
		xfer(1'b1, 8'h70, 8'h55);
		rdchk(8'h70, 8'h00);
		xfer(1'b1, `IDX_CAL_STATUS, 8'hff);
		rdchk(`IDX_CAL_STATUS, 8'h00);
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, `IDX_OFFSET_LOW, offs[i][7:0]);
			xfer(1'b1, `IDX_OFFSET_HIGH, offs[i][15:8]);
			adc_sample <= smp[i];
			repeat (3) @(posedge hclk);
			chk(out_sample, exp_out(smp[i], offs[i]));
		end
		rdchk(`IDX_OFFSET_HIGH, 8'h80);
		ce <= 1'b0;
		adc_sample <= 12'h001;
		repeat (3) @(posedge hclk);
		chk(out_sample, 12'h800);
		ce <= 1'b1;
		adc_flags <= 2'b10;
		repeat (3) @(posedge hclk);
		chk({flag_pair_oe_n, out_flags}, 3'b010);
		xfer(1'b1, `IDX_FLAG_CTRL, 8'h2c);
		repeat (3) @(posedge hclk);
		chk({flag_pair_oe_n, out_flags}, 3'b001);
		xfer(1'b1, `IDX_FLAG_CTRL, 8'h20);
		repeat (3) @(posedge hclk);
		chk({flag_pair_oe_n, out_flags}, 3'b100);
		rdchk(`IDX_FLAG_CTRL, 8'h20);
		xfer(1'b1, `IDX_PLL_CAL, 8'h0c);
		repeat (3) @(posedge hclk);
		rdchk(`IDX_CAL_STATUS, 8'h01);
		repeat (10) @(posedge hclk);
		xfer(1'b1, `IDX_PLL_CAL, 8'h0c);
		xfer(1'b1, `IDX_PLL_CAL, 8'h08);
		repeat (3) @(posedge hclk);
		chk(pulses, 2);
		dly(8'h0e, 1);
		dly(8'h20, 1);
		pll_is_source <= 1'b1;
		dly(8'h2e, 16);
		dly(8'h22, 2);
		dly(8'h2c, 15);
		decimation_active <= 1'b1;
		dly(8'h2e, 1);
		decimation_active <= 1'b0;
		pll_is_source <= 1'b0;
		dly(8'h2e, 1);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		rdchk(`IDX_PLL_CLK, 8'h00);
		end_of_test();
	end
endmodule // tb
